// file: inc/wdt_map.vh
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WDT_OFF_STATUS 8'h00
`define WDT_OFF_CONTROL 8'h04
`define WDT_OFF_CONFIG 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDT_ST_TIMEOUT 4
`define WDT_ST_PWRDOWN 3
`define WDT_ST_GEN_HI 2
`define WDT_CTL_PS_HI 5
`define WDT_CTL_PS_LO 1
`define WDT_CTL_SWEN 0
`define WDT_CFG_MODE_HI 4
`define WDT_CFG_MODE_LO 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WDT_RST_STATUS 8'h18
`define WDT_RST_PS 5'h0b
`define WDT_RST_CONTROL 8'h16
`define WDT_RST_CONFIG 14'h3fff

// ----------------------------------------
// Mode codes and period limits
// ----------------------------------------
`define WDT_MODE_OFF 2'h0
`define WDT_MODE_SOFT 2'h1
`define WDT_MODE_AWAKE 2'h2
`define WDT_MODE_ALWAYS 2'h3
`define WDT_PS_MAX 5'h12

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDT_CLK_NS 4
`define WDT_TICK_NS 1000000
// 1 ms of 4 ns cycles, sized to the divider width
`define WDT_TICK_CYCLES 18'h3d090

`endif

// file: verilog/wdt_tick.v
`timescale 1ns/1ps
`include "wdt_map.vh"

module wdt_tick #(
    parameter [17:0] TICK_CYCLES = `WDT_TICK_CYCLES
) (
    input wire clk_i,   // System clock
    input wire rst_i,   // Synchronous reset, high
    input wire clr_i,   // Restart the base interval
    output reg tick_o   // One-cycle pulse per base interval
);

    reg [17:0] div;

    // ----------------------------------------
    // Base interval divider
    // ----------------------------------------
    // Stands in for the slow internal oscillator
    always @(posedge clk_i)
    begin
        if (rst_i || clr_i)
        begin
            div <= 18'h00000;
            tick_o <= 1'b0;
        end
        else if (div == TICK_CYCLES - 18'h00001)
        begin
            div <= 18'h00000;
            tick_o <= 1'b1;
        end
        else
        begin
            div <= div + 18'h00001;
            tick_o <= 1'b0;
        end
    end

endmodule

// file: verilog/wdt_wb.v
`timescale 1ns/1ps

module wdt_wb (
    input wire clk_i,    // System clock
    input wire rst_i,    // Synchronous reset, high
    input wire cyc_i,    // Bus cycle
    input wire stb_i,    // Strobe
    input wire we_i,     // Write enable
    output wire wr_o,    // Write strobe, one cycle
    output wire rd_o,    // Read strobe, one cycle
    output reg ack_o     // Acknowledge
);

    // ----------------------------------------
    // Access strobes
    // ----------------------------------------
    // Taken once, in the cycle before ack
    assign wr_o = cyc_i && stb_i && we_i && !ack_o;
    assign rd_o = cyc_i && stb_i && !we_i && !ack_o;

    // Ack one cycle after the request, dropped next
    always @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

endmodule

// file: verilog/wdt_top.v
`timescale 1ns/1ps
`include "wdt_map.vh"

// Behaviour
// - Counter advances on a 1 ms base tick, independent of core activity.
// - Two-bit mode field picks one of four modes; 00 keeps watchdog off.
// - Mode 11 runs the watchdog always, asleep too, ignoring soft enable.
// - Mode 10 runs while awake, stops in sleep, ignoring soft enable.
// - Mode 01 runs only while the soft enable bit is set.
// - Period select field chooses a time-out from 1 ms to 262144 ms (2^18 ticks).
// - Any reset loads period select for a two-second time-out.
// - Count clears on reset, clear instruction and whenever disabled.
// - Count clears on oscillator fail and stays clear during start-up timer.
// - Sleep entry clears the count; counting resumes if enabled in sleep.
// - Sleep exit clears the count again and holds it during start-up timer.
// - Time-out in sleep wakes the core instead of resetting it.
// - Time-out clears timeout flag bit 4; power-down flag bit 3 is cleared by sleep entry and by a time-out in sleep.
// - Oscillator divider changes leave the count untouched.
// - Wake by time-out clears both timeout and power-down flags.

module wdt_top #(
    parameter [17:0] TICK_CYCLES = `WDT_TICK_CYCLES
) (
    input wire clk_i,           // System clock, 250 MHz
    input wire rst_i,           // Synchronous reset, high
    input wire cyc_i,           // Wishbone cycle
    input wire stb_i,           // Wishbone strobe
    input wire we_i,            // Wishbone write enable
    input wire [7:0] adr_i,     // Wishbone byte address
    input wire [3:0] sel_i,     // Wishbone byte selects
    input wire [31:0] dat_i,    // Wishbone write data
    output wire [31:0] dat_o,   // Wishbone read data
    output wire ack_o,          // Wishbone acknowledge
    input wire sleep_i,         // Core is in sleep
    input wire clear_wdt_i,     // Watchdog clear instruction, pulse
    input wire osc_fail_i,      // Oscillator fail event, pulse
    input wire ost_running_i,   // Oscillator start-up timer running
    output reg wdt_reset_o,     // Device reset request, pulse
    output reg wake_o,          // Wake from sleep request, pulse
    output reg wdt_active_o     // Watchdog currently enabled
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [7:0] status_flags;
    reg [7:0] watchdog_control_reg;
    reg [13:0] config_word_one;
    reg [31:0] rd_data;
    reg [18:0] count;
    reg sleep_q;
    reg enabled;
    reg clear_cnt;
    reg timeout;
    reg [31:0] next_rd_data;
    wire wr_stb;
    wire rd_stb;
    wire tick;
    wire [1:0] watchdog_mode_select;
    wire soft_watchdog_enable;
    wire [4:0] watchdog_period_select;
    wire sleep_enter;
    wire sleep_exit;
    wire [7:0] status_wr;
    wire [7:0] control_wr;
    wire [13:0] config_wr;
    wire [15:0] status_mrg;
    wire [15:0] control_mrg;
    wire [15:0] config_mrg;

    assign watchdog_mode_select = config_word_one[`WDT_CFG_MODE_HI:`WDT_CFG_MODE_LO];
    assign soft_watchdog_enable = watchdog_control_reg[`WDT_CTL_SWEN];
    assign watchdog_period_select = watchdog_control_reg[`WDT_CTL_PS_HI:`WDT_CTL_PS_LO];
    assign sleep_enter = sleep_i && !sleep_q;
    assign sleep_exit = !sleep_i && sleep_q;
    assign dat_o = rd_data;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Last count of the period: 2^ps ticks, ps clipped at 18
    function [18:0] period_last;
        input [4:0] ps;
        reg [4:0] lim;
        begin
            lim = (ps > `WDT_PS_MAX) ? `WDT_PS_MAX : ps;
            period_last = (19'h00001 << lim) - 19'h00001;
        end
    endfunction

    // Byte-lane merge of a write into a stored value
    function [15:0] lane_merge;
        input [15:0] old_val;
        input [15:0] new_val;
        input [1:0] sel;
        begin
            lane_merge[7:0] = sel[0] ? new_val[7:0] : old_val[7:0];
            lane_merge[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
        end
    endfunction

    // Merged words, cut back to each register's width
    assign status_mrg = lane_merge({8'h00, status_flags}, dat_i[15:0], sel_i[1:0]);
    assign control_mrg = lane_merge({8'h00, watchdog_control_reg}, dat_i[15:0], sel_i[1:0]);
    assign config_mrg = lane_merge({2'h0, config_word_one}, dat_i[15:0], sel_i[1:0]);
    assign status_wr = status_mrg[7:0];
    assign control_wr = control_mrg[7:0];
    assign config_wr = config_mrg[13:0];

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    // Bus handshake
    wdt_wb u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .wr_o(wr_stb),
        .rd_o(rd_stb),
        .ack_o(ack_o)
    );

    // Base tick, restarted with the count
    wdt_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(clear_cnt),
        .tick_o(tick)
    );

    // ----------------------------------------
    // Enable and clear decode
    // ----------------------------------------
    // Mode table for the run condition
    always @*
    begin
        case (watchdog_mode_select)
            `WDT_MODE_ALWAYS: enabled = 1'b1;
            `WDT_MODE_AWAKE: enabled = !sleep_i;
            `WDT_MODE_SOFT: enabled = soft_watchdog_enable;
            `WDT_MODE_OFF: enabled = 1'b0;
            default: enabled = 1'b0;
        endcase
    end

    // Every source that forces the count to zero, other than reset and time-out
    always @*
    begin
        clear_cnt = 1'b0;
        if (!enabled)
            clear_cnt = 1'b1;
        if (clear_wdt_i)
            clear_cnt = 1'b1;
        if (osc_fail_i || ost_running_i)
            clear_cnt = 1'b1;
        if (sleep_enter)
            clear_cnt = 1'b1;
        if (sleep_exit)
            clear_cnt = 1'b1;
    end

    // Terminal count reached on a tick
    always @*
    begin
        timeout = !clear_cnt && tick && (count == period_last(watchdog_period_select));
    end

    // ----------------------------------------
    // Watchdog counter
    // ----------------------------------------
    // Only the base tick advances it, never the core clock divider
    always @(posedge clk_i)
    begin
        if (rst_i)
            count <= 19'h00000;
        else if (clear_cnt || timeout)
            count <= 19'h00000;
        else if (tick)
            count <= count + 19'h00001;
    end

    // Sleep edge history
    always @(posedge clk_i)
    begin
        if (rst_i)
            sleep_q <= 1'b0;
        else
            sleep_q <= sleep_i;
    end

    // ----------------------------------------
    // Time-out actions
    // ----------------------------------------
    // Wake in sleep, device reset when awake
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wdt_reset_o <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            wake_o <= timeout && sleep_i;
            wdt_reset_o <= timeout && !sleep_i;
        end
    end

    // Enabled indication
    always @(posedge clk_i)
    begin
        if (rst_i)
            wdt_active_o <= 1'b0;
        else
            wdt_active_o <= enabled;
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Hardware updates win over software writes
    always @(posedge clk_i)
    begin
        if (rst_i)
            status_flags <= `WDT_RST_STATUS;
        else
        begin
            if (wr_stb && adr_i == `WDT_OFF_STATUS)
                status_flags[`WDT_ST_GEN_HI:0] <= status_wr[`WDT_ST_GEN_HI:0];
            if (clear_wdt_i)
            begin
                status_flags[`WDT_ST_TIMEOUT] <= 1'b1;
                status_flags[`WDT_ST_PWRDOWN] <= 1'b1;
            end
            if (sleep_enter)
            begin
                status_flags[`WDT_ST_TIMEOUT] <= 1'b1;
                status_flags[`WDT_ST_PWRDOWN] <= 1'b0;
            end
            if (timeout && sleep_i)
            begin
                status_flags[`WDT_ST_TIMEOUT] <= 1'b0;
                status_flags[`WDT_ST_PWRDOWN] <= 1'b0;
            end
            else if (timeout)
                status_flags[`WDT_ST_TIMEOUT] <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control and configuration
    // ----------------------------------------
    // Period returns to two seconds on any reset, own reset included
    always @(posedge clk_i)
    begin
        if (rst_i)
            watchdog_control_reg <= `WDT_RST_CONTROL;
        else if (timeout && !sleep_i)
            watchdog_control_reg <= `WDT_RST_CONTROL;
        else if (wr_stb && adr_i == `WDT_OFF_CONTROL)
            watchdog_control_reg <= control_wr & 8'h3f;
    end

    // Configuration word holding the mode field
    always @(posedge clk_i)
    begin
        if (rst_i)
            config_word_one <= `WDT_RST_CONFIG;
        else if (wr_stb && adr_i == `WDT_OFF_CONFIG)
            config_word_one <= config_wr;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped addresses read as zero
    always @*
    begin
        case (adr_i)
            `WDT_OFF_STATUS: next_rd_data = {24'h000000, status_flags};
            `WDT_OFF_CONTROL: next_rd_data = {24'h000000, watchdog_control_reg};
            `WDT_OFF_CONFIG: next_rd_data = {18'h00000, config_word_one};
            default: next_rd_data = 32'h00000000;
        endcase
    end

    // Data registered alongside ack
    always @(posedge clk_i)
    begin
        if (rst_i)
            rd_data <= 32'h00000000;
        else if (rd_stb)
            rd_data <= next_rd_data;
    end

endmodule

// file: verif/wdt_top_props.sv
`timescale 1ns/1ps
// ------------
// Port checker
// ------------
module wdt_props #(
    parameter [17:0] TICK_CYCLES = 18'h8
) (
    input logic clk_i, // Clock
    input logic rst_i, // Reset
    input logic cyc_i, // Bus cycle
    input logic stb_i, // Strobe
    input logic we_i, // Write
    input logic ack_o, // Acknowledge
    input logic sleep_i, // Core asleep
    input logic clear_wdt_i, // Clear
    input logic osc_fail_i, // Osc fail
    input logic ost_running_i, // Start-up timer
    input logic wdt_reset_o, // Reset request
    input logic wake_o, // Wake request
    input logic wdt_active_o // Enabled
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Any time-out request
    wire fire = wdt_reset_o | wake_o;
    AST_RST_AWAKE: assert property (wdt_reset_o |-> !$past(sleep_i))
        else $error("reset while asleep");
    AST_WAKE_ASLEEP: assert property (wake_o |-> $past(sleep_i))
        else $error("wake while awake");
    AST_ONE_KIND: assert property (!(wdt_reset_o && wake_o))
        else $error("reset and wake");
    AST_CLR_HOLD: assert property (clear_wdt_i |=> !fire [*7])
        else $error("early after clear");
    AST_FAIL_CLR: assert property (osc_fail_i |=> !fire)
        else $error("fire after osc fail");
    AST_OST_HOLD: assert property (ost_running_i |=> !fire)
        else $error("fire in start-up");
    AST_SLEEP_EDGE: assert property ($changed(sleep_i) |=> !fire [*7])
        else $error("early after sleep edge");
    AST_NEEDS_EN: assert property (fire |-> $past(wdt_active_o, 2))
        else $error("fire while disabled");
    // Main scenarios reached
    cover property (wdt_reset_o);
    cover property (wake_o);
    cover property (cyc_i && stb_i && we_i && ack_o);
endmodule
bind wdt_top wdt_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .sleep_i(sleep_i), .clear_wdt_i(clear_wdt_i),
    .osc_fail_i(osc_fail_i), .ost_running_i(ost_running_i), .wdt_reset_o(wdt_reset_o),
    .wake_o(wake_o), .wdt_active_o(wdt_active_o));

// file: verif/wdt_top_bench.sv
`timescale 1ns/1ps
`include "wdt_map.vh"
// ------------
// Bench
// ------------
module wdt_top_bench;
    localparam int N = 8;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc_i = 1'h0;
    logic stb_i = 1'h0;
    logic we_i = 1'h0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h3;
    logic [31:0] dat_i = 32'h0;
    logic sleep_i = 1'h0;
    logic clear_wdt_i = 1'h0;
    logic osc_fail_i = 1'h0;
    logic ost_running_i = 1'h0;
    logic [31:0] dat_o;
    logic ack_o, wdt_reset_o, wake_o, wdt_active_o;
    logic [1:0] m;
    int mismatches = 0;
    int n_tests = 0;
    int cnt;

    wdt_top #(.TICK_CYCLES(N)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i),
        .clear_wdt_i(clear_wdt_i), .osc_fail_i(osc_fail_i), .ost_running_i(ost_running_i),
        .wdt_reset_o(wdt_reset_o), .wake_o(wake_o), .wdt_active_o(wdt_active_o));

    // Clock, 4 ns
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic final_report;
    begin
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    end
    endtask

    // Counts edges until a time-out request or the limit
    task automatic waitp(input int lim, output int c);
    begin
        c = 0;
        while (wdt_reset_o !== 1'h1 && wake_o !== 1'h1 && c < lim)
        begin
            @(posedge clk_i);
            c++;
        end
        if (lim > 100 && c == lim)
        begin
            chk(c, 0);
            final_report;
        end
    end
    endtask

    // Classic single bus cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
    begin
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (ack_o !== 1'h1 && i < 20);
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        if (i >= 20)
        begin
            chk(i, 0);
            final_report;
        end
        else
            @(posedge clk_i);
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
    begin
        wb(1'h1, a, d, q);
    end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
    begin
        wb(1'h0, a, 32'h0, q);
        chk(q, e);
    end
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        rd(`WDT_OFF_STATUS, 32'h18);
        rd(`WDT_OFF_CONTROL, 32'h16);
        rd(`WDT_OFF_CONFIG, 32'h3fff);
        wr(8'h0c, 32'hff);
        rd(8'h0c, 32'h0);
        wr(`WDT_OFF_STATUS, 32'hff);
        rd(`WDT_OFF_STATUS, 32'h1f);
        // A write with no byte lanes leaves the register alone
        sel_i <= 4'h0;
        wr(`WDT_OFF_CONTROL, 32'h00);
        sel_i <= 4'h3;
        rd(`WDT_OFF_CONTROL, 32'h16);
        $display("registers done");
        // Awake time-out for short periods, clear held during setup
        for (int k = 0; k < 4; k++)
        begin
            clear_wdt_i <= 1'h1;
            wr(`WDT_OFF_CONTROL, k << 1);
            clear_wdt_i <= 1'h0;
            waitp(3000, cnt);
            chk(wdt_reset_o, 1'h1);
            chk(cnt >= (N << k) && cnt <= (N << k) + N, 1'h1);
        end
        rd(`WDT_OFF_STATUS, 32'h0f);
        rd(`WDT_OFF_CONTROL, 32'h16);
        $display("periods done");
        // Every mode, soft enable and sleep state
        for (int k = 0; k < 16; k++)
        begin
            m = k[3:2];
            wr(`WDT_OFF_CONFIG, 32'h3fe7 | (m << 3));
            wr(`WDT_OFF_CONTROL, 32'h16 | k[1]);
            sleep_i <= k[0];
            repeat (3) @(posedge clk_i);
            chk(wdt_active_o, m == 3 || (m == 2 && !k[0]) || (m == 1 && k[1]));
        end
        $display("modes done");
        clear_wdt_i <= 1'h1;
        wr(`WDT_OFF_CONTROL, 32'h0);
        clear_wdt_i <= 1'h0;
        waitp(3000, cnt);
        chk(wake_o, 1'h1);
        rd(`WDT_OFF_STATUS, 32'h07);
        sleep_i <= 1'h0;
        wr(`WDT_OFF_CONFIG, 32'h3fe7);
        waitp(40, cnt);
        chk(cnt, 40);
        ost_running_i <= 1'h1;
        wr(`WDT_OFF_CONFIG, 32'h3fff);
        waitp(40, cnt);
        chk(cnt, 40);
        ost_running_i <= 1'h0;
        repeat (10)
        begin
            osc_fail_i <= 1'h1;
            @(posedge clk_i);
            osc_fail_i <= 1'h0;
            waitp(5, cnt);
            chk(cnt, 5);
        end
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        rd(`WDT_OFF_CONTROL, 32'h16);
        rd(`WDT_OFF_CONFIG, 32'h3fff);
        $display("events done");
        final_report;
    end
endmodule
